// [verilog/pfc_pkg.sv]
// Constants for the fault interrupt configuration bank: command selects,
// field positions, reset values and reset-extension timing.
// Assumes a single 40 MHz system clock.
package pfc_pkg;

  // Register selects carried by the host read/write commands.
  localparam logic [1:0] SEL_OVERTEMP  = 2'h0;
  localparam logic [1:0] SEL_SUPPLY    = 2'h1;
  localparam logic [1:0] SEL_THR_DELAY = 2'h2;

  // Overtemp interrupt configuration fields.
  localparam int         BOOST_EN_BIT  = 3;
  localparam int         SECOND_BUCK_EN_BIT  = 1;
  localparam int         FIRST_BUCK_EN_BIT  = 0;
  localparam logic [7:0] OVERTEMP_MASK = 8'h0b;
  localparam logic [7:0] OVERTEMP_RST  = 8'h00;

  // Supply-low interrupt configuration fields.
  localparam int         SUPPLY_EN_BIT = 4;
  localparam logic [7:0] SUPPLY_MASK   = 8'h10;
  localparam logic [7:0] SUPPLY_RST    = 8'h00;

  // Threshold and reset-extension fields.
  localparam int         THR_LSB       = 4;
  localparam int         EXT_LSB       = 0;
  localparam logic [7:0] THR_DLY_MASK  = 8'h33;
  localparam logic [7:0] THR_DLY_RST   = 8'h03;

  // Warning vector positions.
  localparam int         WARN_FIRST_BUCK    = 0;
  localparam int         WARN_SECOND_BUCK    = 1;
  localparam int         WARN_BOOST    = 2;
  localparam int         WARN_SUPPLY   = 3;
  localparam int         WARN_N        = 4;

  // Reset extension least times in milliseconds and the clock rate.
  localparam longint     CLK_HZ        = 40000000;
  localparam longint     EXT0_MS       = 2;
  localparam longint     EXT1_MS       = 11;
  localparam longint     EXT2_MS       = 21;
  localparam longint     EXT3_MS       = 31;
  localparam int         EXT_CNT_W     = 24;
  localparam logic [EXT_CNT_W-1:0] EXT0_CYC = EXT_CNT_W'((EXT0_MS * CLK_HZ + 999) / 1000);
  localparam logic [EXT_CNT_W-1:0] EXT1_CYC = EXT_CNT_W'((EXT1_MS * CLK_HZ + 999) / 1000);
  localparam logic [EXT_CNT_W-1:0] EXT2_CYC = EXT_CNT_W'((EXT2_MS * CLK_HZ + 999) / 1000);
  localparam logic [EXT_CNT_W-1:0] EXT3_CYC = EXT_CNT_W'((EXT3_MS * CLK_HZ + 999) / 1000);

endpackage

// [verilog/pfc_reset_ext.sv]
// Microcontroller reset extension timer.
// Assumes the request and selects come from logic on the same clock.
`timescale 1ns/100ps
module pfc_reset_ext #(
  parameter int                              CNT_W = pfc_pkg::EXT_CNT_W,
  parameter logic [pfc_pkg::EXT_CNT_W-1:0]   CYC0  = pfc_pkg::EXT0_CYC,
  parameter logic [pfc_pkg::EXT_CNT_W-1:0]   CYC1  = pfc_pkg::EXT1_CYC,
  parameter logic [pfc_pkg::EXT_CNT_W-1:0]   CYC2  = pfc_pkg::EXT2_CYC,
  parameter logic [pfc_pkg::EXT_CNT_W-1:0]   CYC3  = pfc_pkg::EXT3_CYC
) (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       hold_i,
  input  wire logic [1:0] sel_i,
  input  wire logic       reverse_i,
  output logic            mcu_rst_n_o
);

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic             rst_n_q;
  logic             rst_n_d;
  logic [CNT_W-1:0] delay;
  logic [1:0]       code;

  always_comb begin
    code = reverse_i ? ~sel_i : sel_i;
    unique case (code)
      2'h0: delay = CYC0;
      2'h1: delay = CYC1;
      2'h2: delay = CYC2;
      default: delay = CYC3;
    endcase
    cnt_d   = cnt_q;
    rst_n_d = 1'b1;
    if (hold_i) begin
      cnt_d   = delay;
      rst_n_d = 1'b0;
    end else if (cnt_q != '0) begin
      cnt_d   = cnt_q - CNT_W'(1);
      rst_n_d = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q   <= '0;
      rst_n_q <= 1'b0;
    end else begin
      cnt_q   <= cnt_d;
      rst_n_q <= rst_n_d;
    end
  end

  assign mcu_rst_n_o = rst_n_q;

endmodule

// [verilog/pfc_fault_irq_cfg.sv]
// Configuration bank for fault interrupts, supply threshold and reset extension.
// Assumes the host command port is on CLK_SYS_I; warnings and the fuse are pins.
`timescale 1ns/100ps
module pfc_fault_irq_cfg #(
  parameter logic [pfc_pkg::EXT_CNT_W-1:0] EXT0_CYC = pfc_pkg::EXT0_CYC,
  parameter logic [pfc_pkg::EXT_CNT_W-1:0] EXT1_CYC = pfc_pkg::EXT1_CYC,
  parameter logic [pfc_pkg::EXT_CNT_W-1:0] EXT2_CYC = pfc_pkg::EXT2_CYC,
  parameter logic [pfc_pkg::EXT_CNT_W-1:0] EXT3_CYC = pfc_pkg::EXT3_CYC
) (
  input  wire logic       CLK_SYS_I,
  input  wire logic       RST_N_I,
  input  wire logic       CMD_VALID_I,
  input  wire logic       CMD_WRITE_I,
  input  wire logic [1:0] CMD_SEL_I,
  input  wire logic [7:0] CMD_WDATA_I,
  output logic      [7:0] CMD_RDATA_O,
  output logic            CMD_RVALID_O,
  input  wire logic       DIAG_STATE_I,
  input  wire logic       CFG_LOCK_I,
  input  wire logic       BOOST_OVERTEMP_WARNING_FLAG_I,
  input  wire logic       SECOND_BUCK_OT_WARN_I,
  input  wire logic       FIRST_BUCK_OT_WARN_I,
  input  wire logic       SUPPLY_LOW_I,
  input  wire logic       ORDER_FUSE_I,
  input  wire logic       OUTPUT_ENABLE_SET_I,
  input  wire logic [2:0] FLAG_CLEAR_I,
  output logic            BOOST_OT_WARNING_FLAG_O,
  output logic            SECOND_BUCK_OT_WARNING_FLAG_O,
  output logic            FIRST_BUCK_OT_WARNING_FLAG_O,
  output logic            OUTPUT_ENABLE_CONTROL_O,
  output logic            SHARED_EN_IRQ_O,
  output logic            SHARED_EN_IRQ_OE_O,
  output logic            SAFE_REQ_O,
  output logic      [1:0] SUPPLY_LOW_THRESHOLD_O,
  output logic            MCU_RST_N_O,
  input  wire logic       MCU_RST_REQ_I
);

  localparam int SN = pfc_pkg::WARN_N + 1;

  logic          rst_meta_q;
  logic          rst_sync_q;
  logic [SN-1:0] pin_meta_q;
  logic [SN-1:0] pin_sync_q;

  // Reset release through two flip-flops.
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // Pin synchronisers; the first stage feeds only the second.
  // They keep running through reset, so the ordering fuse has crossed both
  // stages before it is latched at the first edge after reset release.
  // A warning held during reset is therefore seen as soon as reset ends.
  always_ff @(posedge CLK_SYS_I) begin
    pin_meta_q <= {ORDER_FUSE_I, SUPPLY_LOW_I, BOOST_OVERTEMP_WARNING_FLAG_I, SECOND_BUCK_OT_WARN_I, FIRST_BUCK_OT_WARN_I};
    pin_sync_q <= pin_meta_q;
  end

  logic [pfc_pkg::WARN_N-1:0] warn;
  logic                       fuse_s;
  assign warn   = pin_sync_q[pfc_pkg::WARN_N-1:0];
  assign fuse_s = pin_sync_q[pfc_pkg::WARN_N];

  logic [7:0] ot_cfg_q;
  logic [7:0] ot_cfg_d;
  logic [7:0] sup_cfg_q;
  logic [7:0] sup_cfg_d;
  logic [7:0] thr_cfg_q;
  logic [7:0] thr_cfg_d;
  logic [2:0] flag_q;
  logic [2:0] flag_d;
  logic       oe_ctl_q;
  logic       oe_ctl_d;
  logic       pull_q;
  logic       pull_d;
  logic       hit_q;
  logic       hit_d;
  logic       safe_q;
  logic       safe_d;
  logic       fuse_q;
  logic       fuse_d;
  logic       fuse_done_q;
  logic       fuse_done_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic       rvalid_q;
  logic       rvalid_d;
  logic       wr_ok;
  logic [3:0] irq_src;

  // Host writes land only in the diagnostic state with the lock bit clear.
  // Reserved bits are masked, so they always read back as zero.
  always_comb begin
    wr_ok     = CMD_VALID_I && CMD_WRITE_I && DIAG_STATE_I && !CFG_LOCK_I;
    ot_cfg_d  = ot_cfg_q;
    sup_cfg_d = sup_cfg_q;
    thr_cfg_d = thr_cfg_q;
    if (wr_ok) begin
      unique case (CMD_SEL_I)
        pfc_pkg::SEL_OVERTEMP:  ot_cfg_d  = CMD_WDATA_I & pfc_pkg::OVERTEMP_MASK;
        pfc_pkg::SEL_SUPPLY:    sup_cfg_d = CMD_WDATA_I & pfc_pkg::SUPPLY_MASK;
        pfc_pkg::SEL_THR_DELAY: thr_cfg_d = CMD_WDATA_I & pfc_pkg::THR_DLY_MASK;
        default: ;
      endcase
    end

    // A read answers one cycle after its strobe and holds its data until the next read.
    rvalid_d = CMD_VALID_I && !CMD_WRITE_I;
    rdata_d  = rdata_q;
    if (rvalid_d) begin
      unique case (CMD_SEL_I)
        pfc_pkg::SEL_OVERTEMP:  rdata_d = ot_cfg_q;
        pfc_pkg::SEL_SUPPLY:    rdata_d = sup_cfg_q;
        pfc_pkg::SEL_THR_DELAY: rdata_d = thr_cfg_q;
        default:                rdata_d = 8'h00;
      endcase
    end

    // Status flags: a warning in the clear cycle keeps the flag set.
    flag_d = (flag_q & ~FLAG_CLEAR_I) | warn[pfc_pkg::WARN_BOOST:pfc_pkg::WARN_FIRST_BUCK];

    // Each enabled warning is an interrupt source; the supply-low event has no flag here.
    irq_src[pfc_pkg::WARN_FIRST_BUCK]  = warn[pfc_pkg::WARN_FIRST_BUCK] && ot_cfg_q[pfc_pkg::FIRST_BUCK_EN_BIT];
    irq_src[pfc_pkg::WARN_SECOND_BUCK]  = warn[pfc_pkg::WARN_SECOND_BUCK] && ot_cfg_q[pfc_pkg::SECOND_BUCK_EN_BIT];
    irq_src[pfc_pkg::WARN_BOOST]  = warn[pfc_pkg::WARN_BOOST] && ot_cfg_q[pfc_pkg::BOOST_EN_BIT];
    irq_src[pfc_pkg::WARN_SUPPLY] = warn[pfc_pkg::WARN_SUPPLY] && sup_cfg_q[pfc_pkg::SUPPLY_EN_BIT];
    hit_d = |irq_src;

    // The interrupt wins over a software set in the same cycle.
    oe_ctl_d = hit_d ? 1'b0 : (OUTPUT_ENABLE_SET_I ? 1'b1 : oe_ctl_q);
    pull_d   = !oe_ctl_d;
    safe_d   = hit_d && !hit_q;

    // The ordering fuse is taken once, at the first edge after reset release,
    // so a fuse line that moves later cannot change the extension order.
    fuse_done_d = 1'b1;
    fuse_d      = fuse_done_q ? fuse_q : fuse_s;
  end

  always_ff @(posedge CLK_SYS_I or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      ot_cfg_q    <= pfc_pkg::OVERTEMP_RST;
      sup_cfg_q   <= pfc_pkg::SUPPLY_RST;
      thr_cfg_q   <= pfc_pkg::THR_DLY_RST;
      flag_q      <= '0;
      oe_ctl_q    <= 1'b0;
      pull_q      <= 1'b1;
      hit_q       <= 1'b0;
      safe_q      <= 1'b0;
      fuse_q      <= 1'b0;
      fuse_done_q <= 1'b0;
      rdata_q     <= 8'h00;
      rvalid_q    <= 1'b0;
    end else begin
      ot_cfg_q    <= ot_cfg_d;
      sup_cfg_q   <= sup_cfg_d;
      thr_cfg_q   <= thr_cfg_d;
      flag_q      <= flag_d;
      oe_ctl_q    <= oe_ctl_d;
      pull_q      <= pull_d;
      hit_q       <= hit_d;
      safe_q      <= safe_d;
      fuse_q      <= fuse_d;
      fuse_done_q <= fuse_done_d;
      rdata_q     <= rdata_d;
      rvalid_q    <= rvalid_d;
    end
  end

  // Reset extension timer; the latched fuse reverses the code order.
  pfc_reset_ext #(
    .CNT_W (pfc_pkg::EXT_CNT_W),
    .CYC0  (EXT0_CYC),
    .CYC1  (EXT1_CYC),
    .CYC2  (EXT2_CYC),
    .CYC3  (EXT3_CYC)
  ) u_reset_ext (
    .clk_i       (CLK_SYS_I),
    .rst_n_i     (rst_sync_q),
    .hold_i      (MCU_RST_REQ_I),
    .sel_i       (thr_cfg_q[pfc_pkg::EXT_LSB +: 2]),
    .reverse_i   (fuse_q),
    .mcu_rst_n_o (MCU_RST_N_O)
  );

  // The shared pin is open drain: its data is always low and the enable
  // pulls it down whenever the output-enable control bit is clear.
  assign CMD_RDATA_O                   = rdata_q;
  assign CMD_RVALID_O                  = rvalid_q;
  assign FIRST_BUCK_OT_WARNING_FLAG_O  = flag_q[pfc_pkg::WARN_FIRST_BUCK];
  assign SECOND_BUCK_OT_WARNING_FLAG_O = flag_q[pfc_pkg::WARN_SECOND_BUCK];
  assign BOOST_OT_WARNING_FLAG_O       = flag_q[pfc_pkg::WARN_BOOST];
  assign OUTPUT_ENABLE_CONTROL_O       = oe_ctl_q;
  assign SHARED_EN_IRQ_O               = 1'b0;
  assign SHARED_EN_IRQ_OE_O            = pull_q;
  assign SAFE_REQ_O                    = safe_q;
  assign SUPPLY_LOW_THRESHOLD_O        = thr_cfg_q[pfc_pkg::THR_LSB +: 2];

endmodule

// [verification/pfc_fault_irq_cfg_sva.sv]
// Assertions on the ports of the fault interrupt configuration bank.
// Assumes it is bound to the top module; one clock domain.
`timescale 1ns/100ps
module pfc_fault_irq_cfg_sva (
  input wire logic CLK_SYS_I,
  input wire logic RST_N_I,
  input wire logic BOOST_OVERTEMP_WARNING_FLAG_I,
  input wire logic SECOND_BUCK_OT_WARN_I,
  input wire logic FIRST_BUCK_OT_WARN_I,
  input wire logic BOOST_OT_WARNING_FLAG_O,
  input wire logic SECOND_BUCK_OT_WARNING_FLAG_O,
  input wire logic FIRST_BUCK_OT_WARNING_FLAG_O,
  input wire logic OUTPUT_ENABLE_CONTROL_O,
  input wire logic SHARED_EN_IRQ_O,
  input wire logic SHARED_EN_IRQ_OE_O,
  input wire logic SAFE_REQ_O,
  input wire logic MCU_RST_N_O,
  input wire logic MCU_RST_REQ_I
);
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!RST_N_I);
  chk_boost_flag_set: assert property ($rose(BOOST_OVERTEMP_WARNING_FLAG_I) |-> ##[3:4] BOOST_OT_WARNING_FLAG_O)
    else $error("boost flag not set");
  chk_second_buck_flag_set: assert property ($rose(SECOND_BUCK_OT_WARN_I) |-> ##[3:4] SECOND_BUCK_OT_WARNING_FLAG_O)
    else $error("second buck flag not set");
  chk_first_buck_flag_set: assert property ($rose(FIRST_BUCK_OT_WARN_I) |-> ##[3:4] FIRST_BUCK_OT_WARNING_FLAG_O)
    else $error("first buck flag not set");
  chk_pin_follows_oe: assert property (SHARED_EN_IRQ_OE_O == !OUTPUT_ENABLE_CONTROL_O)
    else $error("pin pull-down does not follow enable bit");
  chk_pin_drives_low: assert property (SHARED_EN_IRQ_O == 1'b0)
    else $error("shared pin data not low");
  chk_safe_one_cycle: assert property (SAFE_REQ_O |-> !OUTPUT_ENABLE_CONTROL_O ##1 !SAFE_REQ_O)
    else $error("safe request malformed");
  chk_oe_clear_safe: assert property ($fell(OUTPUT_ENABLE_CONTROL_O) |-> SAFE_REQ_O)
    else $error("enable bit cleared without safe request");
  chk_mcu_reset_hold: assert property (MCU_RST_REQ_I |=> !MCU_RST_N_O)
    else $error("mcu reset not held");
  cover property ($rose(SAFE_REQ_O));
  cover property ($rose(MCU_RST_N_O));
  cover property ($fell(OUTPUT_ENABLE_CONTROL_O));
endmodule
bind pfc_fault_irq_cfg pfc_fault_irq_cfg_sva i_sva (.*);

// [verification/pfc_host_model.sv]
// Host model that issues register commands to the configuration bank.
// Assumes commands are single-cycle strobes on the bank's clock.
`timescale 1ns/100ps
module pfc_host_model (
  input  wire logic       clk_i,
  output logic            valid_o,
  output logic            write_o,
  output logic      [1:0] sel_o,
  output logic      [7:0] wdata_o,
  input  wire logic [7:0] rdata_i,
  input  wire logic       rvalid_i
);
  initial begin
    valid_o = 1'b0;
    write_o = 1'b0;
    sel_o   = 2'h0;
    wdata_o = 8'h5a;
  end
  // Outside a strobe the data lines are inverted so stale values never pass.
  task automatic xfer(input logic wr, input logic [1:0] s, input logic [7:0] wd,
                      output logic [7:0] rd, output logic ok);
    @(posedge clk_i);
    valid_o <= 1'b1;
    write_o <= wr;
    sel_o   <= s;
    wdata_o <= wd;
    @(posedge clk_i);
    valid_o <= 1'b0;
    write_o <= ~wr;
    wdata_o <= ~wd;
    @(posedge clk_i);
    rd = rdata_i;
    ok = rvalid_i;
  endtask
endmodule

// [verification/pfc_fault_irq_cfg_bench.sv]
// Self-checking bench for the fault interrupt configuration bank.
// Assumes the host model drives the command port; extension counts are shortened.
`timescale 1ns/100ps
module pfc_fault_irq_cfg_bench;
  localparam logic [23:0] CYC [4] = '{24'h4, 24'h8, 24'hc, 24'h10};
  localparam logic [7:0]  MASK [4] = '{8'h0b, 8'h10, 8'h33, 8'h00};
  logic       clk = 1'b0, rst_n = 1'b0, diag = 1'b0, lock = 1'b0, fuse = 1'b0;
  logic       oe_set = 1'b0, req = 1'b0;
  logic [3:0] warn = 4'h0;
  logic [2:0] clr = 3'h0;
  logic [7:0] rnd = 8'h0e, d;
  logic [7:0] exp [4];
  wire        valid, write, rvalid, oe_ctl, pin, pin_oe, safe, mrst_n;
  wire  [2:0] flags;
  wire  [1:0] sel, thr;
  wire  [7:0] wdata, rdata;
  int         errors = 0, tests_run = 0, cycles = 0, n;
  pfc_host_model i_host (.clk_i(clk), .valid_o(valid), .write_o(write), .sel_o(sel),
    .wdata_o(wdata), .rdata_i(rdata), .rvalid_i(rvalid));
  pfc_fault_irq_cfg #(.EXT0_CYC(CYC[0]), .EXT1_CYC(CYC[1]), .EXT2_CYC(CYC[2]), .EXT3_CYC(CYC[3])) i_dut (
    .CLK_SYS_I(clk), .RST_N_I(rst_n), .CMD_VALID_I(valid), .CMD_WRITE_I(write), .CMD_SEL_I(sel),
    .CMD_WDATA_I(wdata), .CMD_RDATA_O(rdata), .CMD_RVALID_O(rvalid), .DIAG_STATE_I(diag),
    .CFG_LOCK_I(lock), .BOOST_OVERTEMP_WARNING_FLAG_I(warn[2]), .SECOND_BUCK_OT_WARN_I(warn[1]),
    .FIRST_BUCK_OT_WARN_I(warn[0]), .SUPPLY_LOW_I(warn[3]), .ORDER_FUSE_I(fuse),
    .OUTPUT_ENABLE_SET_I(oe_set), .FLAG_CLEAR_I(clr), .BOOST_OT_WARNING_FLAG_O(flags[2]),
    .SECOND_BUCK_OT_WARNING_FLAG_O(flags[1]), .FIRST_BUCK_OT_WARNING_FLAG_O(flags[0]),
    .OUTPUT_ENABLE_CONTROL_O(oe_ctl), .SHARED_EN_IRQ_O(pin), .SHARED_EN_IRQ_OE_O(pin_oe),
    .SAFE_REQ_O(safe), .SUPPLY_LOW_THRESHOLD_O(thr), .MCU_RST_N_O(mrst_n), .MCU_RST_REQ_I(req));
  always #12.5 clk = ~clk;
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic conclude();
    if (errors == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] want);
    tests_run++;
    if (seen !== want) begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, want, seen);
    end
  endtask
  task automatic cmd(input logic wr, input logic [1:0] s, input logic [7:0] wd);
    logic [7:0] rd;
    logic       ok;
    i_host.xfer(wr, s, wd, rd, ok);
    if (wr && diag && !lock) exp[s] = wd & MASK[s];
    check("read answer", 8'(ok), 8'(!wr));
    if (!wr) check("read data", rd, exp[s]);
    check("threshold", 8'(thr), 8'(exp[2][5:4]));
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      conclude();
    end
  end
  initial begin
    for (int f = 0; f < 2; f++) begin
      rst_n <= 1'b0;
      fuse <= f[0];
      diag <= 1'b0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      exp = '{8'h00, 8'h00, 8'h03, 8'h00};
      for (int s = 0; s < 4; s++) cmd(1'b0, s[1:0], 8'h00);
      for (int i = 0; i < 24; i++) begin
        rnd = lfsr(rnd);
        d = lfsr(rnd);
        @(posedge clk);
        diag <= d[7] | d[6];
        lock <= d[5] & d[4];
        cmd(1'b1, rnd[1:0], d);
        cmd(1'b0, rnd[1:0], 8'h00);
      end
      @(posedge clk);
      diag <= 1'b1;
      lock <= 1'b0;
      for (int s = 0; s < 4; s++) begin
        cmd(1'b1, s[1:0], 8'hff);
        cmd(1'b0, s[1:0], 8'h00);
      end
      // Each code is measured from the last request edge to the reset release.
      for (int c = 0; c < 4; c++) begin
        cmd(1'b1, 2'h2, 8'(c));
        @(posedge clk);
        req <= 1'b1;
        @(posedge clk);
        req <= 1'b0;
        n = 0;
        @(posedge clk);
        while (mrst_n !== 1'b1 && n < 100) begin
          n++;
          @(posedge clk);
        end
        check("extension", 8'(n), 8'((f ? CYC[3 - c] : CYC[c]) + 1));
      end
      for (int w = 0; w < 8; w++) begin
        d = 8'(w[2]) << (w[1:0] == 2'h3 ? 4 : w[1:0] == 2'h2 ? 3 : w[1:0]);
        cmd(1'b1, {1'b0, &w[1:0]}, d);
        @(posedge clk);
        oe_set <= 1'b1;
        @(posedge clk);
        oe_set <= 1'b0;
        warn[w[1:0]] <= 1'b1;
        n = 0;
        repeat (6) begin
          @(posedge clk);
          n += safe;
        end
        check("enable bit", 8'(oe_ctl), 8'(!w[2]));
        check("pin pull", 8'(pin_oe), 8'(w[2]));
        check("pin data", 8'(pin), 8'h00);
        check("safe pulses", 8'(n), 8'(w[2]));
        if (w[1:0] != 2'h3) check("flag", 8'(flags[w[1:0]]), 8'h01);
        warn <= 4'h0;
        repeat (4) @(posedge clk);
        clr <= 3'h7;
        @(posedge clk);
        clr <= 3'h0;
      end
    end
    conclude();
  end
endmodule
